// file: rtl/ifgc_host.sv
// host controller: AXI4-Lite slave that drives the receiver link
// one clock; assumes the device end of ifgc_link_if
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "ifgc_map.svh"
module ifgc_host #(
	parameter int unsigned POWERUP_CYCLES = `POWERUP_CYC,
	parameter int unsigned SETTLE_CYCLES = `SETTLE_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	ifgc_link_if.host link
);
	import ifgc_pkg::*;

	logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
	logic [7:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;
	logic [7:0] laddr_q, laddr_d, ldata_q, ldata_d;
	logic lwr_q, lwr_d, err_q, err_d, calib_q, calib_d;
	logic [31:0] pw_q, pw_d, st_q, st_d;
	logic busy_q, busy_d;
	// set once power-all is written, so calibration waits for power-up
	logic pok_q, pok_d;
	logic go;

	assign s_awready = !aw_q && !b_q;
	assign s_wready = !w_q && !b_q;
	assign s_arready = !r_q;
	assign go = aw_q && w_q && !b_q;

	always_comb begin
		aw_d = aw_q;
		w_d = w_q;
		b_d = b_q;
		r_d = r_q;
		awa_d = awa_q;
		wd_d = wd_q;
		rd_d = rd_q;
		br_d = br_q;
		rr_d = rr_q;
		laddr_d = laddr_q;
		ldata_d = ldata_q;
		lwr_d = 1'b0;
		err_d = err_q;
		calib_d = calib_q;
		pw_d = (pw_q != 0) ? pw_q - 32'd1 : pw_q;
		st_d = (st_q != 0) ? st_q - 32'd1 : st_q;
		busy_d = link.cal_busy;
		pok_d = pok_q;
		if (s_awvalid && s_awready) begin
			aw_d = 1'b1;
			awa_d = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			w_d = 1'b1;
			wd_d = s_wdata;
		end
		if (go) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			b_d = 1'b1;
			br_d = 2'b00;
			unique case (awa_q)
				`OFS_CMD: begin
					laddr_d = wd_q[15:8];
					ldata_d = wd_q[7:0];
					if (laddr_d == `ADDR_STAGE2 &&
						ldata_d[4:0] > `STAGE2_MAX) begin
						err_d = 1'b1; // see (R3)
						br_d = 2'b10;
					end else if (laddr_d == `ADDR_CAL && ldata_d[`CAL_BIT] &&
						(!pok_q || pw_q != 0 || link.cal_busy)) begin
						err_d = 1'b1; // see (R6)
						br_d = 2'b10;
					end else begin
						lwr_d = 1'b1;
						if (laddr_d == `ADDR_POWER) begin
							pok_d = (ldata_d[2:0] == `POWER_ALL); // see (R6)
						end
						if (laddr_d == `ADDR_POWER &&
							ldata_d[2:0] == `POWER_ALL) begin
							pw_d = POWERUP_CYCLES; // see (R6)
						end
						if (laddr_d == `ADDR_CAL && ldata_d[`CAL_BIT]) begin
							calib_d = 1'b0; // see (R4)
						end
					end
				end
				`OFS_STATUS: begin
					if (wd_q[`STAT_ERR] && s_wstrb[0]) begin
						err_d = 1'b0;
					end
				end
				default: br_d = 2'b10;
			endcase
		end
		if (b_q && s_bready) begin
			b_d = 1'b0;
		end
		// calibration done: start the settling wait
		if (busy_q && !link.cal_busy) begin
			st_d = SETTLE_CYCLES; // see (R10)
			calib_d = 1'b1;
		end
		if (s_arvalid && s_arready) begin
			r_d = 1'b1;
			rr_d = 2'b00;
			unique case (s_araddr)
				`OFS_CMD: rd_d = {16'h0000, laddr_q, ldata_q};
				`OFS_DATA: rd_d = 32'h0;
				`OFS_STATUS: rd_d = {28'h0, err_q,
					calib_q && st_q == 0, calib_q, link.cal_busy};
				`OFS_READ: rd_d = {24'h0, link.rdata};
				default: begin
					rd_d = 32'h0;
					rr_d = 2'b10;
				end
			endcase
		end else if (r_q && s_rready) begin
			r_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			b_q <= 1'b0;
			r_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0;
			rd_q <= 32'h0;
			br_q <= 2'b00;
			rr_q <= 2'b00;
			laddr_q <= 8'h00;
			ldata_q <= 8'h00;
			lwr_q <= 1'b0;
			err_q <= 1'b0;
			calib_q <= 1'b0;
			pw_q <= 32'h0;
			st_q <= 32'h0;
			busy_q <= 1'b0;
			pok_q <= 1'b0;
		end else begin
			aw_q <= aw_d;
			w_q <= w_d;
			b_q <= b_d;
			r_q <= r_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			rd_q <= rd_d;
			br_q <= br_d;
			rr_q <= rr_d;
			laddr_q <= laddr_d;
			ldata_q <= ldata_d;
			lwr_q <= lwr_d;
			err_q <= err_d;
			calib_q <= calib_d;
			pw_q <= pw_d;
			st_q <= st_d;
			busy_q <= busy_d;
			pok_q <= pok_d;
		end
	end

	assign s_bvalid = b_q;
	assign s_bresp = br_q;
	assign s_rvalid = r_q;
	assign s_rdata = rd_q;
	assign s_rresp = rr_q;
	// read address follows the last command address for OFS_READ
	assign link.wr_en = lwr_q; // see (R5)
	assign link.addr = laddr_q;
	assign link.wdata = ldata_q;
endmodule

// file: rtl/ifgc_map.svh
// register map, field positions, reset values and timing counts
// assumes a 100 MHz aclk on both ends
`ifndef IFGC_MAP_SVH
`define IFGC_MAP_SVH

`define CLK_MHZ 100
// device register addresses on the link
`define ADDR_POWER 8'h01
`define ADDR_CAL 8'h02
`define ADDR_STAGE1 8'h0b
`define ADDR_STAGE2 8'h0c
`define POWER_ALL 3'b110
`define CAL_BIT 0
`define DISABLE_BIT 6
`define STAGE2_RESET 8'h80
`define STAGE1_RESET 8'h01
`define STAGE2_MAX 5'h0c
// times in microseconds
`define POWERUP_US 500
`define CAL_RUN_US 1300
`define SETTLE_US 1500
`define POWERUP_CYC (`POWERUP_US * `CLK_MHZ)
`define CAL_RUN_CYC (`CAL_RUN_US * `CLK_MHZ)
`define SETTLE_CYC (`SETTLE_US * `CLK_MHZ)
// controller AXI4-Lite register byte offsets
`define OFS_CMD 8'h00
`define OFS_DATA 8'h04
`define OFS_STATUS 8'h08
`define OFS_READ 8'h0c
`define STAT_BUSY 0
`define STAT_CALIB 1
`define STAT_READY 2
`define STAT_ERR 3
`endif

// file: rtl/ifgc_pkg.sv
// types shared by both ends of the gain and calibration link
// assumes ifgc_map.svh for the numbers
package ifgc_pkg;
	typedef logic [7:0] addr_type;
	typedef logic [7:0] data_type;
	typedef enum logic [1:0] {
		cal_idle = 2'b00,
		cal_run = 2'b01,
		cal_done = 2'b10
	} cal_state_type;
	typedef enum logic [1:0] {
		host_idle = 2'b00,
		host_wait = 2'b01,
		host_read = 2'b10
	} host_state_type;
endpackage

// file: rtl/ifgc_link_if.sv
// register link between the host controller and the receiver control
// one clock, write strobe with address and data, combinational read
`timescale 1ns/1ps
interface ifgc_link_if;
	logic wr_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic cal_busy;
	modport host (output wr_en, output addr, output wdata,
		input rdata, input cal_busy);
	modport device (input wr_en, input addr, input wdata,
		output rdata, output cal_busy);
endinterface

// file: rtl/ifgc_device.sv
// receiver gain and calibration register bank, device end
// assumes the host keeps its own ordering and code limits
//
// Contract
// (R1) stage2 gain is binary 0..12 dB
// (R2) disable bit routes both manual gains out
// (R3) host writes no stage2 code above twelve
// (R4) host calibrates before receiving
// (R5) host keeps reference and LO running
// (R6) power all, then calibrate after 500us
// (R7) writing trigger one starts calibration
// (R8) calibration runs on; zero ignored
// (R9) results kept until master reset
// (R10) host waits 1.5ms settling after calibration
// (R11) rising edge starts, clears after 1.3ms
// (R12) disable zero auto, one manual
// (R13) stage2 reads back, resets to 0x80
`timescale 1ns/1ps
`include "ifgc_map.svh"
module ifgc_device #(
	parameter int unsigned CAL_CYCLES = `CAL_RUN_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	ifgc_link_if.device link,
	output logic auto_gain_disable,
	output logic [4:0] stage1_gain_out,
	output logic [4:0] stage2_gain_out,
	output logic gain_manual,
	output logic [2:0] block_power_select,
	output logic cal_active,
	output logic cal_valid
);
	import ifgc_pkg::*;

	logic [7:0] power_q, power_d;
	logic [7:0] stage1_q, stage1_d;
	logic [7:0] stage2_q, stage2_d;
	logic trig_q, trig_d;
	logic valid_q, valid_d;
	logic [31:0] cnt_q, cnt_d;
	cal_state_type st_q, st_d;
	logic [5:0] s1;

	function automatic logic hit(input logic [7:0] a);
		hit = link.wr_en && (link.addr == a);
	endfunction

	always_comb begin
		power_d = power_q;
		stage1_d = stage1_q;
		stage2_d = stage2_q;
		trig_d = trig_q;
		valid_d = valid_q;
		cnt_d = cnt_q;
		st_d = st_q;
		if (hit(`ADDR_POWER)) begin
			power_d = link.wdata;
		end
		if (hit(`ADDR_STAGE1)) begin
			stage1_d = link.wdata;
		end
		if (hit(`ADDR_STAGE2)) begin
			stage2_d = link.wdata; // see (R13)
		end
		if (hit(`ADDR_CAL)) begin
			trig_d = link.wdata[`CAL_BIT];
		end
		unique case (st_q)
			cal_idle, cal_done: begin
				// start on a written one rising from zero
				if (hit(`ADDR_CAL) && link.wdata[`CAL_BIT] && !trig_q) begin
					st_d = cal_run; // see (R7) see (R11)
					cnt_d = '0;
					trig_d = 1'b1;
				end
			end
			cal_run: begin
				trig_d = 1'b1; // see (R8)
				if (cnt_q == CAL_CYCLES - 1) begin
					st_d = cal_done; // see (R11)
					trig_d = 1'b0;
					valid_d = 1'b1; // see (R9)
				end else begin
					cnt_d = cnt_q + 32'd1;
				end
			end
			default: st_d = cal_idle;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_q <= 8'h00;
			stage1_q <= `STAGE1_RESET;
			stage2_q <= `STAGE2_RESET; // see (R13)
			trig_q <= 1'b0;
			valid_q <= 1'b0; // see (R9)
			cnt_q <= '0;
			st_q <= cal_idle;
		end else begin
			power_q <= power_d;
			stage1_q <= stage1_d;
			stage2_q <= stage2_d;
			trig_q <= trig_d;
			valid_q <= valid_d;
			cnt_q <= cnt_d;
			st_q <= st_d;
		end
	end

	assign s1 = stage1_q[5:0];
	assign auto_gain_disable = stage1_q[`DISABLE_BIT];
	assign gain_manual = auto_gain_disable; // see (R2) see (R12)
	// stage1 signed code clipped to its low five bits for the gain path
	assign stage1_gain_out = auto_gain_disable ? s1[4:0] : 5'h00;
	assign stage2_gain_out = auto_gain_disable ? stage2_q[4:0] : 5'h00; // see (R1)
	assign block_power_select = power_q[2:0];
	assign cal_active = (st_q == cal_run);
	assign cal_valid = valid_q;
	assign link.cal_busy = (st_q == cal_run);

	always_comb begin
		unique case (link.addr)
			`ADDR_POWER: link.rdata = power_q;
			`ADDR_CAL: link.rdata = {7'h00, trig_q};
			`ADDR_STAGE1: link.rdata = stage1_q;
			`ADDR_STAGE2: link.rdata = stage2_q;
			default: link.rdata = 8'h00;
		endcase
	end
endmodule

// file: tb/ifgc_properties.sv
// link checker between host controller and receiver device
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module ifgc_properties #(
	parameter int unsigned CAL_CYCLES = 20,
	parameter int unsigned POWERUP_CYCLES = 10
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic cal_busy
);
	logic [15:0] run_q, run_d, pwr_q, pwr_d;
	logic cal_wr, s2_wr;
	assign cal_wr = wr_en && addr == 8'h02;
	assign s2_wr = wr_en && addr == 8'h0c;
	always_comb begin
		run_d = cal_busy ? run_q + 16'h1 : 16'h0;
		pwr_d = pwr_q + 16'(pwr_q != 16'hffff);
		if (wr_en && addr == 8'h01)
			pwr_d = 16'h0;
	end
	always_ff @(posedge aclk) begin
		run_q <= aresetn ? run_d : 16'h0;
		pwr_q <= aresetn ? pwr_d : 16'h0;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_s2;
		s2_wr |=> addr != 8'h0c || rdata == $past(wdata);
	endproperty
	property p_lim;
		s2_wr |-> wdata[4:0] <= 5'h0c;
	endproperty
	property p_go;
		cal_wr && wdata[0] && !cal_busy |=> cal_busy;
	endproperty
	property p_hold;
		$rose(cal_busy) |-> cal_busy [*8];
	endproperty
	property p_zero;
		cal_wr && !wdata[0] && run_q < CAL_CYCLES - 1 && cal_busy |=> cal_busy;
	endproperty
	property p_len;
		$fell(cal_busy) |-> run_q == CAL_CYCLES;
	endproperty
	property p_clr;
		$fell(cal_busy) && addr == 8'h02 |-> !rdata[0];
	endproperty
	property p_pwr;
		cal_wr && wdata[0] |-> pwr_q >= POWERUP_CYCLES - 1;
	endproperty
	a_s2: assert property (p_s2) else $error("gain readback");
	a_lim: assert property (p_lim) else $error("gain code");
	a_go: assert property (p_go) else $error("no start");
	a_hold: assert property (p_hold) else $error("run cut");
	a_zero: assert property (p_zero) else $error("zero stopped");
	a_len: assert property (p_len) else $error("run length");
	a_clr: assert property (p_clr) else $error("trigger kept");
	a_pwr: assert property (p_pwr) else $error("early start");
	c_done: cover property ($fell(cal_busy));
	c_s2: cover property (s2_wr);
	c_zero: cover property (cal_wr && !wdata[0] && cal_busy);
endmodule

// file: tb/if_gain_and_calibration_ctrl_tb.sv
// bench: AXI4-Lite master on the host, device on the far link end
// assumes counts shortened to 20, 10 and 30 cycles
`timescale 1ns/1ps
module if_gain_and_calibration_ctrl_tb;
	logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0;
	logic s_bready = 0, s_arvalid = 0, s_rready = 0;
	logic [7:0] s_awaddr = 0, s_araddr = 0;
	logic [31:0] s_wdata = 0, s_rdata;
	logic [3:0] s_wstrb = 4'hf;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp;
	logic auto_gain_disable, gain_manual, cal_active, cal_valid;
	logic [4:0] stage1_gain_out, stage2_gain_out, c;
	logic [2:0] block_power_select;
	logic [33:0] q[$];
	int err_count = 0, checked = 0;
	ifgc_link_if link();
	ifgc_host #(.POWERUP_CYCLES(10), .SETTLE_CYCLES(30)) i_ifgc_host(.*);
	ifgc_device #(.CAL_CYCLES(20)) i_ifgc_device(.*);
	ifgc_properties #(.CAL_CYCLES(20), .POWERUP_CYCLES(10)) i_chk(
		.aclk(aclk), .aresetn(aresetn), .wr_en(link.wr_en),
		.addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
		.cal_busy(link.cal_busy));
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [1:0] r);
		logic g, h;
		q.push_back({r, 32'h0});
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= {16'h0, d};
		s_awvalid <= 1;
		s_wvalid <= 1;
		s_bready <= 1;
		do begin
			@(negedge aclk);
			g = s_awready;
			h = s_wready;
			@(posedge aclk);
			if (g) s_awvalid <= 0;
			if (h) s_wvalid <= 0;
		end while (s_awvalid && !g || s_wvalid && !h);
		do @(posedge aclk); while (!s_bvalid);
		s_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		logic g;
		q.push_back(e);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1;
		s_rready <= 1;
		do begin
			@(negedge aclk);
			g = s_arready;
			@(posedge aclk);
		end while (!g);
		s_arvalid <= 0;
		do @(posedge aclk); while (!s_rvalid);
		s_rready <= 0;
	endtask
	always @(posedge aclk) begin
		if (s_bvalid && s_bready)
			chk({s_bresp, 32'h0}, q.pop_front());
		if (s_rvalid && s_rready)
			chk({s_rresp, s_rdata}, q.pop_front());
	end
	initial forever #5 aclk = ~aclk;
	initial begin
		#200us;
		err_count++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(32'h3b141f35));
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		rd(8'h08, 34'h0);
		wr(8'h00, 16'h0201, 2'b10);
		rd(8'h08, 34'h8);
		wr(8'h08, 16'h8, 2'b00);
		wr(8'h10, 16'h0, 2'b10);
		rd(8'h1c, {2'b10, 32'h0});
		wr(8'h00, 16'h0c0d, 2'b10);
		for (int i = 0; i < 6; i++) begin
			c = (i == 0) ? 5'h0c : 5'($urandom % 13);
			wr(8'h00, {8'h0c, 3'h0, c}, 2'b00);
			rd(8'h0c, 34'(c));
			chk(34'(stage2_gain_out), 34'h0);
		end
		wr(8'h00, 16'h0b45, 2'b00);
		// the link write lands on the edge that ends the task
		@(negedge aclk);
		chk({gain_manual, auto_gain_disable, stage1_gain_out,
			stage2_gain_out}, {2'b11, 5'h05, c});
		wr(8'h00, 16'h0106, 2'b00);
		@(negedge aclk);
		chk(34'(block_power_select), 34'h6);
		repeat (10) @(posedge aclk);
		wr(8'h00, 16'h0201, 2'b00);
		@(negedge aclk);
		chk(34'(cal_active), 34'h1);
		wr(8'h00, 16'h0200, 2'b00);
		wr(8'h00, 16'h0201, 2'b10);
		while (cal_active) @(posedge aclk);
		rd(8'h08, 34'ha);
		chk(34'(cal_valid), 34'h1);
		repeat (32) @(posedge aclk);
		rd(8'h08, 34'he);
		rd(8'h0c, 34'h0);
		wr(8'h00, 16'h0201, 2'b00);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		chk({cal_active, cal_valid}, 34'h0);
		aresetn <= 1;
		tally_and_finish;
	end
endmodule
